// >>> inc/mstdc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MSTDC_REGS_SVH
`define MSTDC_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MSTDC_STATUS_OFS 8'h00
`define MSTDC_OFF_OFS 8'h04
`define MSTDC_BLANK_OFS 8'h08
`define MSTDC_FAST_OFS 8'h0C
// ----------------------------------------
// status field positions
// ----------------------------------------
`define MSTDC_ST_IDX_LSB 0
`define MSTDC_ST_MODE1_LSB 5
`define MSTDC_ST_MODE2_LSB 7
`define MSTDC_ST_RUN_BIT 9
`define MSTDC_ST_HOT_BIT 10
`define MSTDC_ST_LOCK_BIT 11
// ----------------------------------------
// translator constants
// ----------------------------------------
`define MSTDC_HOME_IDX 5'h04
`define MSTDC_HOME_MAG 8'hB4
`define MSTDC_FRAC_HIGH 8'h99
`define MSTDC_FRAC_LOW 8'h36
// ----------------------------------------
// timing
// ----------------------------------------
`define MSTDC_CLK_NS 40
`define MSTDC_T_OFF_NS 38000
`define MSTDC_T_BLANK_NS 950
`define MSTDC_T_FAST_NS 19000
`define MSTDC_OFF_CYC (`MSTDC_T_OFF_NS / `MSTDC_CLK_NS)
`define MSTDC_BLANK_CYC ((`MSTDC_T_BLANK_NS + `MSTDC_CLK_NS - 1) / `MSTDC_CLK_NS)
`define MSTDC_FAST_CYC (`MSTDC_T_FAST_NS / `MSTDC_CLK_NS)
`endif

// >>> inc/mstdc_pkg.sv
// shared types of the microstep translator
package mstdc_pkg;
    typedef enum logic [1:0] {MSTDC_SLOW, MSTDC_FAST, MSTDC_MIXED} mstdc_decay_t;
    typedef logic [4:0] mstdc_idx_t;
endpackage : mstdc_pkg

// >>> src/mstdc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module mstdc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // meta_r feeds sync_r only
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= i_d;
            sync_r <= meta_r;
        end
    end

    assign o_q = sync_r;
endmodule : mstdc_sync

// >>> src/mstdc_bridge.sv
// fixed off-time pwm regulator for one full bridge
`timescale 1ns/1ns
module mstdc_bridge
    import mstdc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire mstdc_decay_t i_mode,
    input wire logic i_trip,
    input wire logic [CNT_W-1:0] i_off_cyc,
    input wire logic [CNT_W-1:0] i_blank_cyc,
    input wire logic [CNT_W-1:0] i_fast_cyc,
    output logic o_source,
    output logic o_sink
);
    typedef enum logic [1:0] {BR_IDLE, BR_ON, BR_FAST, BR_SLOW} mstdc_br_state_t;

    mstdc_br_state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, blk_r, fast_rem;
    mstdc_decay_t mode_r;
    logic trip_ok, cnt_end, src_r, snk_r;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign trip_ok = i_trip && (blk_r == '0);
    assign cnt_end = (cnt_r <= CNT_W'(1));
    // fast part longer than off-time means fast for the whole off-time
    assign fast_rem = (i_fast_cyc >= i_off_cyc) ? '0 : i_off_cyc - i_fast_cyc;

    // next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            BR_IDLE: st_nxt = BR_ON;
            BR_ON: begin
                if (trip_ok) begin
                    st_nxt = (i_mode == MSTDC_SLOW) ? BR_SLOW : BR_FAST;
                end
            end
            BR_FAST: begin
                if (cnt_end) begin
                    st_nxt = BR_ON;
                end else if (mode_r == MSTDC_MIXED && cnt_r <= fast_rem) begin
                    st_nxt = BR_SLOW;
                end
            end
            BR_SLOW: begin
                if (cnt_end) begin
                    st_nxt = BR_ON;
                end
            end
            default: st_nxt = BR_IDLE;
        endcase
        if (!i_run) begin
            st_nxt = BR_IDLE;
        end
    end

    // state, off-time and blanking counters
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_r <= BR_IDLE;
            cnt_r <= '0;
            blk_r <= '0;
            mode_r <= MSTDC_MIXED;
        end else begin
            st_r <= st_nxt;
            if (st_r == BR_ON && st_nxt != BR_ON && i_run) begin
                cnt_r <= i_off_cyc;
                mode_r <= i_mode;
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - CNT_W'(1);
            end
            if (st_nxt != st_r && st_nxt != BR_IDLE) begin
                blk_r <= i_blank_cyc;
            end else if (blk_r != '0) begin
                blk_r <= blk_r - CNT_W'(1);
            end
        end
    end

    // drivers registered from the next state
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            src_r <= 1'h0;
            snk_r <= 1'h0;
        end else begin
            src_r <= (st_nxt == BR_ON);
            snk_r <= (st_nxt == BR_ON) || (st_nxt == BR_SLOW);
        end
    end

    assign o_source = src_r;
    assign o_sink = snk_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_mixed_trip;
        st_r == BR_ON && trip_ok && i_run && i_mode == MSTDC_MIXED;
    endsequence

    a_trip_turns_off: assert property (st_r == BR_ON && trip_ok && i_run |=> !o_source)
        else $error("source stayed on after trip");
    a_blank_masks: assert property (st_r == BR_ON && blk_r != '0 && i_run |=> st_r == BR_ON)
        else $error("trip accepted during blanking");
    a_off_holds: assert property ((st_r == BR_FAST || st_r == BR_SLOW) && !cnt_end && i_run
        |=> !o_source)
        else $error("on phase started before off-time ended");
    a_mixed_fast_first: assert property (s_mixed_trip |=> st_r == BR_FAST ##0 !o_sink)
        else $error("mixed decay did not start fast");
endmodule : mstdc_bridge

// >>> src/mstdc_top.sv
// microstep translator with automatic decay selection and apb registers
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "mstdc_regs.svh"
module mstdc_top
    import mstdc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_step,
    input wire logic i_dir,
    input wire logic i_resolution_select_a,
    input wire logic i_resolution_select_b,
    input wire logic i_reset_n,
    input wire logic i_enable_n,
    input wire logic i_sleep_n,
    input wire logic i_thermal_fault,
    input wire logic i_supply_lockout,
    input wire logic i_ph1_current_trip,
    input wire logic i_ph2_current_trip,
    input wire logic [7:0] i_decay_fraction_level,
    output logic [7:0] o_ph1_dac,
    output logic o_ph1_reverse,
    output logic o_ph1_source,
    output logic o_ph1_sink,
    output logic [7:0] o_ph2_dac,
    output logic o_ph2_reverse,
    output logic o_ph2_source,
    output logic o_ph2_sink
);
    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (CNT_W < 11 || CNT_W > 31) begin : g_bad_cnt
        $error("CNT_W must be 11 to 31");
    end

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // quarter-wave magnitude table, 0 to 90 degrees in eighth steps
    function automatic logic [7:0] wave_tbl(input logic [3:0] k);
        case (k)
            4'h0: wave_tbl = 8'hFF;
            4'h1: wave_tbl = 8'hFA;
            4'h2: wave_tbl = 8'hEC;
            4'h3: wave_tbl = 8'hD4;
            4'h4: wave_tbl = 8'hB4;
            4'h5: wave_tbl = 8'h8E;
            4'h6: wave_tbl = 8'h62;
            4'h7: wave_tbl = 8'h32;
            default: wave_tbl = 8'h00;
        endcase
    endfunction : wave_tbl

    // cosine magnitude at an index; period is 16 in magnitude
    function automatic logic [7:0] mag_of(input mstdc_idx_t p);
        logic [3:0] r;
        r = p[3:0];
        mag_of = (r <= 4'h8) ? wave_tbl(r) : wave_tbl(4'(5'h10 - {1'h0, r}));
    endfunction : mag_of

    // cosine negative between 90 and 270 degrees
    function automatic logic neg_of(input mstdc_idx_t p);
        neg_of = (p > 5'h08) && (p < 5'h18);
    endfunction : neg_of

    // phase 2 is phase 1 shifted back a quarter turn
    function automatic mstdc_idx_t ph_idx(input mstdc_idx_t p, input int g);
        ph_idx = (g == 0) ? p : 5'(p - 5'h08);
    endfunction : ph_idx

    // increment per step from the select pins
    function automatic mstdc_idx_t step_inc(input logic a, input logic b);
        case ({b, a})
            2'h0: step_inc = 5'h08;
            2'h1: step_inc = 5'h04;
            2'h2: step_inc = 5'h02;
            default: step_inc = 5'h01;
        endcase
    endfunction : step_inc

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // reset value holds the device at home until pins are seen
    localparam logic [18:0] SYNC_RST = {8'h00, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0,
        1'h1, 1'h0, 4'h0};

    logic [18:0] pin_raw, pin_s;
    logic step_s, dir_s, sel_a_s, sel_b_s, reset_n_s, enable_n_s;
    logic sleep_n_s, hot_s, lock_s;
    logic [1:0] trip_s;
    logic [7:0] frac_s;

    assign pin_raw = {i_decay_fraction_level, i_ph2_current_trip, i_ph1_current_trip,
        i_supply_lockout, i_thermal_fault, i_sleep_n, i_enable_n, i_reset_n,
        i_resolution_select_b, i_resolution_select_a, i_dir, i_step};

    mstdc_sync #(
        .W(19),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_d(pin_raw),
        .o_q(pin_s)
    );

    assign step_s = pin_s[0];
    assign dir_s = pin_s[1];
    assign sel_a_s = pin_s[2];
    assign sel_b_s = pin_s[3];
    assign reset_n_s = pin_s[4];
    assign enable_n_s = pin_s[5];
    assign sleep_n_s = pin_s[6];
    assign hot_s = pin_s[7];
    assign lock_s = pin_s[8];
    assign trip_s = pin_s[10:9];
    assign frac_s = pin_s[18:11];

    // ----------------------------------------
    // translator
    // ----------------------------------------
    mstdc_idx_t idx_r, idx_nxt, inc, idx_fwd, idx_bwd;
    logic step_d_r, step_ok, home, run;
    mstdc_decay_t frac_mode;
    logic [7:0] frac_d_r, frac_r;

    // home forced by reset pin, supply lockout or sleep
    assign home = !reset_n_s || lock_s || !sleep_n_s;
    // enable pin never gates the translator
    assign step_ok = step_s && !step_d_r && !home;
    assign run = reset_n_s && sleep_n_s && !lock_s && !hot_s && !enable_n_s;
    // selects read at the step edge only
    assign inc = step_inc(sel_a_s, sel_b_s);
    assign idx_fwd = 5'(idx_r + inc);
    assign idx_bwd = 5'(idx_r - inc);
    assign idx_nxt = home ? `MSTDC_HOME_IDX : !step_ok ? idx_r
        : dir_s ? idx_fwd : idx_bwd;

    // thresholds on the digitised fraction level
    assign frac_mode = (frac_r > `MSTDC_FRAC_HIGH) ? MSTDC_SLOW
        : (frac_r < `MSTDC_FRAC_LOW) ? MSTDC_FAST : MSTDC_MIXED;

    // the level is a bus of pins: a code caught mid-change is only taken once it repeats
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            frac_d_r <= 8'h00;
            frac_r <= 8'h00;
        end else begin
            frac_d_r <= frac_s;
            frac_r <= (frac_s == frac_d_r) ? frac_s : frac_r;
        end
    end

    // position and step edge detector
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            idx_r <= `MSTDC_HOME_IDX;
            step_d_r <= 1'h0;
        end else begin
            idx_r <= idx_nxt;
            step_d_r <= step_s;
        end
    end

    // ----------------------------------------
    // per-phase levels, decay and bridges
    // ----------------------------------------
    logic [7:0] dac_r [2];
    logic rev_r [2];
    mstdc_decay_t mode_r [2];
    logic [7:0] mag_new [2];
    logic neg_new [2];
    mstdc_decay_t mode_nxt [2];
    logic src [2];
    logic snk [2];
    logic [CNT_W-1:0] off_r, blank_r, fast_r;

    for (genvar g = 0; g < 2; g++) begin : g_ph
        assign mag_new[g] = mag_of(ph_idx(idx_nxt, g));
        assign neg_new[g] = neg_of(ph_idx(idx_nxt, g));
        // falling level follows the fraction input, else slow
        assign mode_nxt[g] = home ? MSTDC_MIXED : !step_ok ? mode_r[g]
            : (mag_new[g] < dac_r[g]) ? frac_mode : MSTDC_SLOW;

        mstdc_bridge #(
            .CNT_W(CNT_W)
        ) u_bridge (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .i_run(run),
            .i_mode(mode_r[g]),
            .i_trip(trip_s[g]),
            .i_off_cyc(off_r),
            .i_blank_cyc(blank_r),
            .i_fast_cyc(fast_r),
            .o_source(src[g]),
            .o_sink(snk[g])
        );
    end

    // levels and polarity follow the next index
    always_ff @(posedge i_sys_clk) begin
        for (int g = 0; g < 2; g++) begin
            if (i_rst) begin
                dac_r[g] <= `MSTDC_HOME_MAG;
                rev_r[g] <= 1'h0;
                mode_r[g] <= MSTDC_MIXED;
            end else begin
                dac_r[g] <= mag_new[g];
                rev_r[g] <= neg_new[g];
                mode_r[g] <= mode_nxt[g];
            end
        end
    end

    assign o_ph1_dac = dac_r[0];
    assign o_ph1_reverse = rev_r[0];
    assign o_ph1_source = src[0];
    assign o_ph1_sink = snk[0];
    assign o_ph2_dac = dac_r[1];
    assign o_ph2_reverse = rev_r[1];
    assign o_ph2_source = src[1];
    assign o_ph2_sink = snk[1];

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic acc, done, wr, hit;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r, rd_mux, status;

    // one wait cycle: pready rises in the second access cycle
    assign acc = i_psel && i_penable && !pready_r;
    assign done = i_psel && i_penable && pready_r;
    assign wr = done && i_pwrite;
    assign hit = (i_paddr == `MSTDC_STATUS_OFS) || (i_paddr == `MSTDC_OFF_OFS)
        || (i_paddr == `MSTDC_BLANK_OFS) || (i_paddr == `MSTDC_FAST_OFS);

    // status word, unused bits read zero
    always_comb begin
        status = 32'h0;
        status[`MSTDC_ST_IDX_LSB +: 5] = idx_r;
        status[`MSTDC_ST_MODE1_LSB +: 2] = mode_r[0];
        status[`MSTDC_ST_MODE2_LSB +: 2] = mode_r[1];
        status[`MSTDC_ST_RUN_BIT] = run;
        status[`MSTDC_ST_HOT_BIT] = hot_s;
        status[`MSTDC_ST_LOCK_BIT] = lock_s;
    end

    assign rd_mux = (i_paddr == `MSTDC_STATUS_OFS) ? status
        : (i_paddr == `MSTDC_OFF_OFS) ? 32'(off_r)
        : (i_paddr == `MSTDC_BLANK_OFS) ? 32'(blank_r)
        : (i_paddr == `MSTDC_FAST_OFS) ? 32'(fast_r) : 32'h0;

    // handshake and read data
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pready_r <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc && !hit;
            prdata_r <= (acc && !i_pwrite) ? rd_mux : 32'h0;
        end
    end

    // timing registers; status is read-only and ignores writes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            off_r <= CNT_W'(`MSTDC_OFF_CYC);
            blank_r <= CNT_W'(`MSTDC_BLANK_CYC);
            fast_r <= CNT_W'(`MSTDC_FAST_CYC);
        end else if (wr) begin
            if (i_paddr == `MSTDC_OFF_OFS) begin
                off_r <= i_pwdata[CNT_W-1:0];
            end
            if (i_paddr == `MSTDC_BLANK_OFS) begin
                blank_r <= i_pwdata[CNT_W-1:0];
            end
            if (i_paddr == `MSTDC_FAST_OFS) begin
                fast_r <= i_pwdata[CNT_W-1:0];
            end
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_step_fwd_full;
        step_ok && dir_s && !sel_a_s && !sel_b_s;
    endsequence

    a_home_on_hold: assert property (home |=> idx_r == 5'h04 && dac_r[0] == 8'hB4
        && dac_r[1] == 8'hB4 && mode_r[0] == MSTDC_MIXED)
        else $error("home state not loaded");
    a_full_step_fwd: assert property (s_step_fwd_full |=> idx_r == 5'($past(idx_r) + 5'h08))
        else $error("full step did not move by eight");
    a_dir_reverse: assert property (step_ok && !dir_s && sel_a_s && sel_b_s
        |=> idx_r == 5'($past(idx_r) - 5'h01))
        else $error("reverse eighth step wrong");
    a_idle_stable: assert property (!step_ok && !home |=> $stable(idx_r))
        else $error("index moved without a step");
    a_reset_ignores: assert property (!reset_n_s |=> idx_r == 5'h04 && !o_ph1_source
        && !o_ph1_sink && !o_ph2_source && !o_ph2_sink)
        else $error("step or drive while reset low");
    a_rise_slow: assert property (step_ok && mag_new[0] >= dac_r[0]
        |=> mode_r[0] == MSTDC_SLOW)
        else $error("rising level not slow decay");
    a_fall_frac: assert property (step_ok && mag_new[1] < dac_r[1] && frac_r < 8'h36
        |=> mode_r[1] == MSTDC_FAST)
        else $error("falling level ignored fraction input");
    a_drv_off: assert property (!run |=> !o_ph1_source && !o_ph1_sink
        && !o_ph2_source && !o_ph2_sink)
        else $error("drivers on while disabled");
    a_step_when_off: assert property (enable_n_s && step_ok |=> idx_r != $past(idx_r))
        else $error("translator stalled while disabled");
endmodule : mstdc_top

// >>> tb/mstdc_ctrl_model.sv
// controller model driving the step, direction and resolution pins
`timescale 1ns/1ns
module mstdc_ctrl_model (
    input wire logic i_sys_clk,
    output logic o_step,
    output logic o_dir,
    output logic o_resolution_select_a,
    output logic o_resolution_select_b
);
    // idle levels at time zero
    initial begin
        o_step = 1'b0;
        o_dir = 1'b1;
        o_resolution_select_a = 1'b0;
        o_resolution_select_b = 1'b0;
    end
    // ----------------------------------------
    // step pulse
    // ----------------------------------------
    // pins settle four clocks ahead so the synchroniser passes them first;
    // hold sets a prompt or a slow pulse
    task automatic do_step(input logic dir, input logic [1:0] sel, input int hold);
        @(posedge i_sys_clk);
        o_dir <= dir;
        o_resolution_select_a <= sel[0];
        o_resolution_select_b <= sel[1];
        repeat (4) @(posedge i_sys_clk);
        o_step <= 1'b1;
        repeat (hold) @(posedge i_sys_clk);
        o_step <= 1'b0;
        repeat (hold) @(posedge i_sys_clk);
    endtask : do_step
endmodule : mstdc_ctrl_model

// >>> tb/microstep_translator_decay_control_tb.sv
// self-checking bench for the microstep translator
`timescale 1ns/1ns
`include "mstdc_regs.svh"
module microstep_translator_decay_control_tb
    import mstdc_pkg::*;
;
    typedef struct packed {logic [31:0] d; logic e;} mstdc_note_t;
    localparam logic [7:0] MAG [0:8] = '{8'hFF, 8'hFA, 8'hEC, 8'hD4, 8'hB4, 8'h8E, 8'h62,
        8'h32, 8'h00};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h0, frac = 8'h80, dac1, dac2;
    logic [31:0] pwdata = 32'h0, prdata;
    logic reset_n = 1'b1, enable_n = 1'b0, sleep_n = 1'b1, hot = 1'b0, lock = 1'b0;
    logic [1:0] trip = 2'h0;
    logic step, dir, sa, sb, pready, pslverr, rev1, rev2, src1, snk1, src2, snk2;
    int errors = 0, check_count = 0, seed = 32'h79f4;
    logic [4:0] idx = `MSTDC_HOME_IDX;
    mstdc_decay_t m1 = MSTDC_MIXED, m2 = MSTDC_MIXED;
    mstdc_note_t notes[$];
    mstdc_note_t cur;
    // free-running 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    mstdc_ctrl_model u_ctrl (.i_sys_clk(clk), .o_step(step), .o_dir(dir),
        .o_resolution_select_a(sa), .o_resolution_select_b(sb));
    mstdc_top u_dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_step(step), .i_dir(dir),
        .i_resolution_select_a(sa), .i_resolution_select_b(sb), .i_reset_n(reset_n),
        .i_enable_n(enable_n), .i_sleep_n(sleep_n), .i_thermal_fault(hot),
        .i_supply_lockout(lock), .i_ph1_current_trip(trip[0]), .i_ph2_current_trip(trip[1]),
        .i_decay_fraction_level(frac), .o_ph1_dac(dac1), .o_ph1_reverse(rev1),
        .o_ph1_source(src1), .o_ph1_sink(snk1), .o_ph2_dac(dac2), .o_ph2_reverse(rev2),
        .o_ph2_source(src2), .o_ph2_sink(snk2));
    // ----------------------------------------
    // expectations and comparisons
    // ----------------------------------------
    function automatic logic [7:0] mag(input logic [4:0] i);
        return MAG[(i[3:0] > 4'd8) ? 4'd0 - i[3:0] : i[3:0]];
    endfunction : mag
    function automatic logic [31:0] st_word();
        return {20'h0, lock, hot, reset_n & sleep_n & !lock & !hot & !enable_n, m2, m1, idx};
    endfunction : st_word
    function automatic logic [7:0] pair(input logic p);
        return p ? {6'h0, src2, snk2} : {6'h0, src1, snk1};
    endfunction : pair
    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg
    task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk_pin
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // bus answers are matched against the oldest note
    always @(negedge clk) begin
        if (pready === 1'b1) begin
            cur = notes.pop_front();
            chk_reg("pslverr", {31'h0, cur.e}, {31'h0, pslverr});
            if (!pwr) chk_reg("prdata", cur.d, prdata);
        end
    end
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    // a hung slave would stall the run, so the wait is bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic er);
        notes.push_back('{e, er});
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++) @(negedge clk);
        if (pready !== 1'b1) begin
            chk_reg("apb_ready", 32'h1, 32'h0);
            end_of_test();
        end
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wait_n
    task automatic check_pos();
        logic [4:0] j;
        j = idx - 5'd8;
        chk_pin("ph1_dac", mag(idx), dac1);
        chk_pin("ph2_dac", mag(j), dac2);
        if (mag(idx) != 0) chk_pin("ph1_rev", {7'h0, idx > 8 && idx < 24}, {7'h0, rev1});
        if (mag(j) != 0) chk_pin("ph2_rev", {7'h0, j > 8 && j < 24}, {7'h0, rev2});
        apb(1'b0, `MSTDC_STATUS_OFS, 32'h0, st_word(), 1'b0);
    endtask : check_pos
    task automatic step_note(input logic d, input logic [1:0] s, input logic taken);
        logic [4:0] nx;
        mstdc_decay_t fm;
        u_ctrl.do_step(d, s, 2 + ($random(seed) & 3));
        nx = d ? idx + (5'd8 >> s) : idx - (5'd8 >> s);
        fm = frac > `MSTDC_FRAC_HIGH ? MSTDC_SLOW : (frac < `MSTDC_FRAC_LOW ? MSTDC_FAST :
            MSTDC_MIXED);
        if (taken) begin
            m1 = mag(nx) < mag(idx) ? fm : MSTDC_SLOW;
            m2 = mag(nx - 5'd8) < mag(idx - 5'd8) ? fm : MSTDC_SLOW;
            idx = nx;
        end
        wait_n(6);
    endtask : step_note
    // both trips land inside the blank window of the new on phase and change nothing
    task automatic trip_check(input logic p, input mstdc_decay_t m);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            trip[p] <= 1'b1;
            @(posedge clk);
            trip[p] <= 1'b0;
            wait_n(3);
            if (k == 1) chk_pin("blanked", 8'h3, pair(p));
        end
    endtask : trip_check
    task automatic pwm_check(input logic p, input mstdc_decay_t m);
        @(posedge clk);
        trip[p] <= 1'b1;
        @(posedge clk);
        trip[p] <= 1'b0;
        wait_n(3);
        chk_pin("fast_part", {7'h0, m == MSTDC_SLOW}, pair(p));
        wait_n(9);
        chk_pin("slow_part", {7'h0, m != MSTDC_FAST}, pair(p));
        wait_n(14);
        chk_pin("back_on", 8'h3, pair(p));
        trip_check(p, m);
    endtask : pwm_check
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_n(6);
        check_pos();
        apb(1'b0, `MSTDC_OFF_OFS, 32'h0, `MSTDC_OFF_CYC, 1'b0);
        apb(1'b0, `MSTDC_BLANK_OFS, 32'h0, `MSTDC_BLANK_CYC, 1'b0);
        apb(1'b0, `MSTDC_FAST_OFS, 32'h0, `MSTDC_FAST_CYC, 1'b0);
        apb(1'b1, 8'h10, 32'hFFFF, 32'h0, 1'b1);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `MSTDC_OFF_OFS, 32'h14, 32'h0, 1'b0);
        apb(1'b1, `MSTDC_BLANK_OFS, 32'h10, 32'h0, 1'b0);
        apb(1'b1, `MSTDC_FAST_OFS, 32'h8, 32'h0, 1'b0);
        apb(1'b1, `MSTDC_STATUS_OFS, 32'hFFFFFFFF, 32'h0, 1'b0);
        apb(1'b0, `MSTDC_OFF_OFS, 32'h0, 32'h14, 1'b0);
        $display("test registers done");
        pwm_check(1'b0, m1);
        pwm_check(1'b1, m2);
        $display("test mixed pwm done");
        for (int k = 0; k < 30; k++) begin
            frac <= 8'($random(seed));
            enable_n <= 1'($random(seed));
            step_note(1'($random(seed)), 2'($random(seed)), 1'b1);
            check_pos();
        end
        enable_n <= 1'b0;
        wait_n(25);
        pwm_check(1'b0, m1);
        pwm_check(1'b1, m2);
        $display("test random steps done");
        // reset pin, sleep, lockout, thermal, enable in turn
        for (int f = 0; f < 5; f++) begin
            @(posedge clk);
            enable_n <= 1'b0;
            step_note(1'b1, 2'b00, 1'b1);
            @(posedge clk);
            case (f)
                0: reset_n <= 1'b0;
                1: sleep_n <= 1'b0;
                2: lock <= 1'b1;
                3: hot <= 1'b1;
                default: enable_n <= 1'b1;
            endcase
            wait_n(4);
            step_note(1'b1, 2'b11, f > 2);
            if (f < 3) begin
                idx = `MSTDC_HOME_IDX;
                m1 = MSTDC_MIXED;
                m2 = MSTDC_MIXED;
            end
            chk_pin("drivers", 8'h0, {4'h0, src1, snk1, src2, snk2});
            check_pos();
            reset_n <= 1'b1;
            sleep_n <= 1'b1;
            lock <= 1'b0;
            hot <= 1'b0;
            $display("test force %0d done", f);
        end
        end_of_test();
    end
endmodule : microstep_translator_decay_control_tb
